// >>> rtl/dfs_pkg.sv
// shared constants and carriers for the data-flash command sequencer
package dfs_pkg;

  // ------------------------------------------------------------
  // register offsets on the plain register port
  // ------------------------------------------------------------
  localparam logic [3:0] REG_CONFIG = 4'h0;
  localparam logic [3:0] REG_ERR_CONFIG = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  localparam logic [3:0] REG_ERR_STATUS = 4'h3;
  localparam logic [3:0] REG_SECURITY = 4'h4;
  localparam logic [3:0] REG_PARAM_INDEX = 4'h5;
  localparam logic [3:0] REG_PARAM_WORD = 4'h6;
  localparam logic [3:0] REG_PROTECT = 4'h7;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CFG_CC_IE = 0;
  localparam int ECFG_SF_IE = 0;
  localparam int ECFG_DF_IE = 1;
  localparam int ST_CMD_COMPLETE_FLAG = 7;
  localparam int ST_ACCESS_ERROR_FLAG = 5;
  localparam int ST_PVIOL = 4;
  localparam int ST_VERR = 1;
  localparam int ST_VUNC = 0;
  localparam int EST_SF = 0;
  localparam int EST_DF = 1;
  localparam int PROT_EN = 15;

  // ------------------------------------------------------------
  // command codes, indices, reset values
  // ------------------------------------------------------------
  localparam logic [7:0] CMD_PROGRAM = 8'h11;
  localparam logic [7:0] CMD_ERASE_SECTOR = 8'h12;
  localparam logic [2:0] IDX_CMD = 3'h0;
  localparam logic [2:0] IDX_ADDR = 3'h1;
  localparam logic [2:0] IDX_WORD_FIRST = 3'h2;
  localparam logic [2:0] IDX_WORD_LAST = 3'h5;
  localparam logic [22:0] SEC_BYTE_ADDR = 23'h7f_ff0f;
  localparam logic [7:0] SEC_DEFAULT = 8'hff;
  localparam logic [15:0] PROT_RESET = 16'h0000;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  typedef enum logic [1:0] {
    ARR_READ,
    ARR_PROGRAM,
    ARR_ERASE,
    ARR_BLANK
  } dfs_op_e;

  typedef struct packed {
    logic req;
    dfs_op_e op;
    logic [22:0] addr;
    logic [15:0] wdata;
  } dfs_arr_req_s;

  typedef struct packed {
    logic done;
    logic err;
    logic uncorr;
    logic [15:0] rdata;
  } dfs_arr_rsp_s;

endpackage

// >>> rtl/dfs_sequencer.sv
// data-flash program / sector-erase command sequencer
//
// Contract
// R1: program params: code, address, up to four words
// R2: word count follows index at launch
// R3: launch by clearing complete flag, then program
// R4: program index outside 2..5 is access error
// R5: command not allowed now is access error
// R6: invalid or odd address is access error
// R7: words past block end are access error
// R8: protected area raises protection violation
// R9: verify read error and uncorrectable flags
// R10: host loads erase code, sector address
// R11: erase, blank check, then complete
// R12: erase index not one is access error
// R13: command irq from complete flag and enable
// R14: error irq from enabled fault flags
// R15: wait mode runs on, irq wakes
// R16: stop held off while command active
// R17: security byte loaded at reset
// R18: new security byte waits for reset
// R19: host programs only erased words
// R20: one to four erased words, verified
// R21: failed launch leaves complete flag set
//
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
module dfs_sequencer import dfs_pkg::*; #(
  parameter logic [22:0] DF_BASE = 23'h10_0000,
  parameter int DF_BYTES = 8192,
  parameter int SECTOR_BYTES = 256
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // register port
  input wire logic [3:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  // system mode and power
  input wire logic cmd_allowed_in,
  input wire logic stop_req_in,
  output logic stop_ack_out,
  // flash array
  output dfs_arr_req_s arr_req_out,
  input wire dfs_arr_rsp_s arr_rsp_in,
  input wire logic ecc_single_in,
  input wire logic ecc_double_in,
  // interrupt requests
  output logic cmd_irq_out,
  output logic err_irq_out
);

  localparam logic [22:0] DF_LAST = 23'(int'(DF_BASE) + DF_BYTES - 1);
  localparam logic [22:0] SECTOR_MASK = 23'(SECTOR_BYTES - 1);

  typedef enum logic [2:0] {
    S_LOAD_SEC,
    S_IDLE,
    S_PROG,
    S_PVERIFY,
    S_ERASE,
    S_EVERIFY
  } dfs_state_e;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  dfs_state_e state, next_state;
  logic cmd_complete_flag, next_cmd_complete_flag;
  logic access_error_flag, next_access_error_flag;
  logic protection_violation_flag, next_protection_violation_flag;
  logic verify_error_flag, next_verify_error_flag;
  logic verify_uncorrectable_flag, next_verify_uncorrectable_flag;
  logic double_fault_flag, next_double_fault_flag;
  logic single_fault_flag, next_single_fault_flag;
  logic cmd_complete_irq_enable, next_cmd_complete_irq_enable;
  logic double_fault_irq_enable, next_double_fault_irq_enable;
  logic single_fault_irq_enable, next_single_fault_irq_enable;
  logic [7:0] security_register, next_security_register;
  logic [2:0] param_index, next_param_index;
  logic [15:0] command_param_word [0:5];
  logic [15:0] next_command_param_word [0:5];
  logic [15:0] protect, next_protect;
  logic [1:0] word_cnt, next_word_cnt;
  logic [1:0] word_last, next_word_last;
  logic [22:0] op_addr, next_op_addr;
  dfs_arr_req_s next_arr_req;

  // ------------------------------------------------------------
  // launch decode
  // ------------------------------------------------------------
  logic [7:0] cmd_code;
  logic [22:0] cmd_addr;
  logic [22:0] group_end;
  logic addr_bad;
  logic is_prog;
  logic is_erase;
  logic launch;
  logic launch_acc;
  logic launch_prot;
  logic [7:0] status_reg;

  assign cmd_code = command_param_word[IDX_CMD][15:8]; // R1 R10
  assign cmd_addr = {command_param_word[IDX_CMD][6:0], command_param_word[IDX_ADDR]};
  assign is_prog = (cmd_code == CMD_PROGRAM);
  assign is_erase = (cmd_code == CMD_ERASE_SECTOR);
  // last byte touched by the word group, index 2 means one word
  assign group_end = cmd_addr + {19'h0, param_index - IDX_WORD_FIRST, 1'b1}; // R2
  assign addr_bad = (cmd_addr < DF_BASE) || (cmd_addr > DF_LAST) || cmd_addr[0]; // R6
  // a set access error or protection violation flag blocks launches until software clears it
  assign launch = reg_wr_in && (reg_addr_in == REG_STATUS) && reg_wdata_in[ST_CMD_COMPLETE_FLAG]
    && cmd_complete_flag && !access_error_flag && !protection_violation_flag; // R3
  // the last byte touched decides, so a group or sector cannot reach into protection
  assign launch_prot = protect[PROT_EN]
    && (((is_prog ? group_end : (cmd_addr | SECTOR_MASK)) - DF_BASE)
    >= {7'h0, protect[14:0], 1'b0}); // R8

  always_comb begin
    launch_acc = 1'b0;
    if (!cmd_allowed_in || addr_bad) begin
      launch_acc = 1'b1; // R5 R6
    end else if (is_prog) begin
      if (param_index < IDX_WORD_FIRST || param_index > IDX_WORD_LAST) launch_acc = 1'b1; // R4
      else if (group_end > DF_LAST) launch_acc = 1'b1; // R7
    end else if (is_erase) begin
      launch_acc = (param_index != IDX_ADDR); // R12
    end else begin
      launch_acc = 1'b1;
    end
  end

  assign status_reg = {cmd_complete_flag, 1'b0, access_error_flag, protection_violation_flag,
    2'b00, verify_error_flag, verify_uncorrectable_flag};

  // ------------------------------------------------------------
  // control next state
  // ------------------------------------------------------------
  always_comb begin
    logic wr_any;
    wr_any = reg_wr_in;
    next_state = state;
    next_cmd_complete_flag = cmd_complete_flag;
    next_access_error_flag = access_error_flag;
    next_protection_violation_flag = protection_violation_flag;
    next_verify_error_flag = verify_error_flag;
    next_verify_uncorrectable_flag = verify_uncorrectable_flag;
    next_cmd_complete_irq_enable = cmd_complete_irq_enable;
    next_double_fault_irq_enable = double_fault_irq_enable;
    next_single_fault_irq_enable = single_fault_irq_enable;
    next_security_register = security_register;
    next_param_index = param_index;
    next_command_param_word = command_param_word;
    next_protect = protect;
    next_word_cnt = word_cnt;
    next_word_last = word_last;
    next_op_addr = op_addr;
    next_arr_req = arr_req_out;
    // fault flags: set wins over a write-one clear
    next_double_fault_flag = double_fault_flag;
    next_single_fault_flag = single_fault_flag;
    if (wr_any && reg_addr_in == REG_ERR_STATUS) begin
      next_double_fault_flag = double_fault_flag & ~reg_wdata_in[EST_DF];
      next_single_fault_flag = single_fault_flag & ~reg_wdata_in[EST_SF];
    end
    next_double_fault_flag = next_double_fault_flag | ecc_double_in;
    next_single_fault_flag = next_single_fault_flag | ecc_single_in;

    if (wr_any) begin
      case (reg_addr_in)
        REG_CONFIG: next_cmd_complete_irq_enable = reg_wdata_in[CFG_CC_IE];
        REG_ERR_CONFIG: begin
          next_double_fault_irq_enable = reg_wdata_in[ECFG_DF_IE];
          next_single_fault_irq_enable = reg_wdata_in[ECFG_SF_IE];
        end
        REG_STATUS: begin
          if (reg_wdata_in[ST_ACCESS_ERROR_FLAG]) next_access_error_flag = 1'b0;
          if (reg_wdata_in[ST_PVIOL]) next_protection_violation_flag = 1'b0;
        end
        REG_PARAM_INDEX: if (cmd_complete_flag) next_param_index = reg_wdata_in[2:0];
        REG_PARAM_WORD: begin
          // parameter words are frozen while a command runs
          if (cmd_complete_flag && param_index <= IDX_WORD_LAST) begin
            next_command_param_word[param_index] = reg_wdata_in;
          end
        end
        REG_PROTECT: if (cmd_complete_flag) next_protect = reg_wdata_in;
        default: ;
      endcase
    end

    case (state)
      S_LOAD_SEC: begin
        next_arr_req.req = 1'b1;
        next_arr_req.op = ARR_READ;
        next_arr_req.addr = SEC_BYTE_ADDR;
        if (arr_rsp_in.done) begin
          next_arr_req.req = 1'b0;
          // a double fault leaves the secured default in place
          if (arr_rsp_in.uncorr) begin
            next_verify_error_flag = 1'b1;
            next_verify_uncorrectable_flag = 1'b1;
          end else begin
            next_security_register = arr_rsp_in.rdata[7:0]; // R17
          end
          next_cmd_complete_flag = 1'b1;
          next_state = S_IDLE;
        end
      end
      S_IDLE: begin
        if (launch) begin
          next_verify_error_flag = 1'b0;
          next_verify_uncorrectable_flag = 1'b0;
          if (launch_acc) begin
            next_access_error_flag = 1'b1; // R21
          end else if (launch_prot) begin
            next_protection_violation_flag = 1'b1; // R21
          end else begin
            next_cmd_complete_flag = 1'b0; // R3
            next_word_cnt = 2'b00;
            next_word_last = 2'(param_index - IDX_WORD_FIRST); // R2
            next_arr_req.req = 1'b1;
            if (is_prog) begin
              next_op_addr = cmd_addr;
              next_arr_req.op = ARR_PROGRAM; // R20
              next_arr_req.addr = cmd_addr;
              next_arr_req.wdata = command_param_word[IDX_WORD_FIRST];
              next_state = S_PROG;
            end else begin
              next_op_addr = cmd_addr & ~SECTOR_MASK;
              next_arr_req.op = ARR_ERASE; // R11
              next_arr_req.addr = cmd_addr & ~SECTOR_MASK;
              next_state = S_ERASE;
            end
          end
        end
      end
      S_PROG: begin
        if (arr_rsp_in.done) begin
          next_arr_req.op = ARR_READ; // R20
          next_state = S_PVERIFY;
        end
      end
      S_PVERIFY: begin
        if (arr_rsp_in.done) begin
          if (arr_rsp_in.err || arr_rsp_in.rdata != arr_req_out.wdata) begin
            next_verify_error_flag = 1'b1; // R9
          end
          if (arr_rsp_in.uncorr) next_verify_uncorrectable_flag = 1'b1; // R9
          if (word_cnt == word_last) begin
            next_arr_req.req = 1'b0;
            next_cmd_complete_flag = 1'b1; // R3
            next_state = S_IDLE;
          end else begin
            next_word_cnt = word_cnt + 2'b01;
            next_arr_req.op = ARR_PROGRAM;
            next_arr_req.addr = op_addr + {20'h0, word_cnt + 2'b01, 1'b0};
            next_arr_req.wdata = command_param_word[3'(word_cnt) + 3'h3];
            next_state = S_PROG;
          end
        end
      end
      S_ERASE: begin
        if (arr_rsp_in.done) begin
          next_arr_req.op = ARR_BLANK; // R11
          next_state = S_EVERIFY;
        end
      end
      S_EVERIFY: begin
        if (arr_rsp_in.done) begin
          next_verify_error_flag = arr_rsp_in.err; // R9
          next_verify_uncorrectable_flag = arr_rsp_in.uncorr; // R9
          next_arr_req.req = 1'b0;
          next_cmd_complete_flag = 1'b1; // R11
          next_state = S_IDLE;
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  // security_register is only ever loaded in S_LOAD_SEC, i.e. after reset
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      state <= S_LOAD_SEC;
      cmd_complete_flag <= 1'b0;
      access_error_flag <= 1'b0;
      protection_violation_flag <= 1'b0;
      verify_error_flag <= 1'b0;
      verify_uncorrectable_flag <= 1'b0;
      double_fault_flag <= 1'b0;
      single_fault_flag <= 1'b0;
      cmd_complete_irq_enable <= 1'b0;
      double_fault_irq_enable <= 1'b0;
      single_fault_irq_enable <= 1'b0;
      security_register <= SEC_DEFAULT; // R18
      param_index <= IDX_CMD;
      for (int i = 0; i < 6; i++) command_param_word[i] <= 16'h0000;
      protect <= PROT_RESET;
      word_cnt <= 2'b00;
      word_last <= 2'b00;
      op_addr <= 23'h00_0000;
      arr_req_out <= '0;
    end else begin
      state <= next_state;
      cmd_complete_flag <= next_cmd_complete_flag;
      access_error_flag <= next_access_error_flag;
      protection_violation_flag <= next_protection_violation_flag;
      verify_error_flag <= next_verify_error_flag;
      verify_uncorrectable_flag <= next_verify_uncorrectable_flag;
      double_fault_flag <= next_double_fault_flag;
      single_fault_flag <= next_single_fault_flag;
      cmd_complete_irq_enable <= next_cmd_complete_irq_enable;
      double_fault_irq_enable <= next_double_fault_irq_enable;
      single_fault_irq_enable <= next_single_fault_irq_enable;
      security_register <= next_security_register;
      param_index <= next_param_index;
      command_param_word <= next_command_param_word;
      protect <= next_protect;
      word_cnt <= next_word_cnt;
      word_last <= next_word_last;
      op_addr <= next_op_addr;
      arr_req_out <= next_arr_req;
    end
  end

  // ------------------------------------------------------------
  // read data, one cycle after the strobe
  // ------------------------------------------------------------
  logic [15:0] next_rdata;

  always_comb begin
    next_rdata = 16'h0000;
    if (reg_rd_in) begin
      case (reg_addr_in)
        REG_CONFIG: next_rdata[CFG_CC_IE] = cmd_complete_irq_enable;
        REG_ERR_CONFIG: next_rdata[1:0] = {double_fault_irq_enable, single_fault_irq_enable};
        REG_STATUS: next_rdata[7:0] = status_reg;
        REG_ERR_STATUS: next_rdata[1:0] = {double_fault_flag, single_fault_flag};
        REG_SECURITY: next_rdata[7:0] = security_register;
        REG_PARAM_INDEX: next_rdata[2:0] = param_index;
        REG_PARAM_WORD: begin
          if (param_index <= IDX_WORD_LAST) next_rdata = command_param_word[param_index];
        end
        REG_PROTECT: next_rdata = protect;
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 16'h0000;
    end else begin
      reg_rdata_out <= next_rdata;
    end
  end

  // ------------------------------------------------------------
  // interrupts and power
  // ------------------------------------------------------------
  // no clock gating here, so wait mode needs nothing beyond the irq
  assign cmd_irq_out = cmd_complete_flag && cmd_complete_irq_enable; // R13 R15
  assign err_irq_out = (double_fault_flag && double_fault_irq_enable)
    || (single_fault_flag && single_fault_irq_enable); // R14
  assign stop_ack_out = stop_req_in && cmd_complete_flag; // R16

endmodule

// >>> tb/dfs_sequencer_asserts.sv
// port-level assertions for the data-flash sequencer
`timescale 1ns/10ps
module dfs_sequencer_asserts import dfs_pkg::*; #(
  parameter int SECTOR_BYTES = 256
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // register port and system
  input wire logic [3:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic cmd_allowed_in,
  input wire logic stop_req_in,
  input wire logic stop_ack_out,
  input wire logic cmd_irq_out,
  // flash array
  input wire dfs_arr_req_s arr_req_out,
  input wire dfs_arr_rsp_s arr_rsp_in
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (sys_rst_in);

  sequence s_step(dfs_op_e o);
    arr_req_out.req && arr_req_out.op == o && arr_rsp_in.done;
  endsequence
  sequence s_refused;
    reg_wr_in && reg_addr_in == REG_STATUS && reg_wdata_in[ST_CMD_COMPLETE_FLAG] && !cmd_allowed_in
      && !arr_req_out.req;
  endsequence

  property p_erase_then_blank;
    s_step(ARR_ERASE) |=> arr_req_out.req && arr_req_out.op == ARR_BLANK;
  endproperty
  a_erase_then_blank: assert property (p_erase_then_blank)
    else $error("no blank check after erase");
  property p_program_then_read;
    s_step(ARR_PROGRAM) |=> arr_req_out.req && arr_req_out.op == ARR_READ
      && $stable(arr_req_out.addr);
  endproperty
  a_program_then_read: assert property (p_program_then_read)
    else $error("no verify read after program");
  property p_req_hold;
    arr_req_out.req && !arr_rsp_in.done |=> arr_req_out.req && $stable(arr_req_out.op)
      && $stable(arr_req_out.addr);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("array request changed before done");
  property p_sec_load;
    $fell(sys_rst_in) |=> arr_req_out.req && arr_req_out.op == ARR_READ
      && arr_req_out.addr == SEC_BYTE_ADDR;
  endproperty
  a_sec_load: assert property (p_sec_load)
    else $error("security byte not read after reset");
  property p_no_self_start;
    !$fell(sys_rst_in) && !arr_req_out.req && !reg_wr_in |=> !arr_req_out.req;
  endproperty
  a_no_self_start: assert property (p_no_self_start)
    else $error("array request without a launch");
  property p_refused;
    s_refused |=> !arr_req_out.req [*2];
  endproperty
  a_refused: assert property (p_refused)
    else $error("disallowed launch reached the array");
  property p_stop;
    stop_req_in && !$fell(sys_rst_in) |-> stop_ack_out == !arr_req_out.req;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop ack does not follow busy");
  property p_irq_quiet;
    arr_req_out.req |-> !cmd_irq_out;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet)
    else $error("command irq while busy");
  property p_erase_base;
    arr_req_out.req && arr_req_out.op == ARR_ERASE |-> int'(arr_req_out.addr) % SECTOR_BYTES == 0;
  endproperty
  a_erase_base: assert property (p_erase_base)
    else $error("erase not at sector base");
endmodule

bind dfs_sequencer dfs_sequencer_asserts #(.SECTOR_BYTES(SECTOR_BYTES)) i_dfs_sequencer_asserts (
  .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .cmd_allowed_in(cmd_allowed_in),
  .stop_req_in(stop_req_in), .stop_ack_out(stop_ack_out), .cmd_irq_out(cmd_irq_out),
  .arr_req_out(arr_req_out), .arr_rsp_in(arr_rsp_in));

// >>> tb/dfs_flash_model.sv
// behavioural flash array answering the sequencer's array requests
`timescale 1ns/10ps
module dfs_flash_model import dfs_pkg::*; #(
  parameter int SECTOR_BYTES = 256
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // request side and fault injection
  input wire dfs_arr_req_s arr_req_in,
  input wire logic [3:0] lat_in,
  input wire logic inj_err_in,
  input wire logic inj_uncorr_in,
  // response
  output dfs_arr_rsp_s arr_rsp_out
);
  logic [15:0] mem [int];
  logic [3:0] cnt;
  int base;

  // security byte value is arbitrary
  initial mem[int'(SEC_BYTE_ADDR)] = 16'hff5a;

  function automatic logic [15:0] rd_word(int a);
    return mem.exists(a) ? mem[a] : 16'hffff;
  endfunction

  always @(posedge mclk_in) begin
    // lines toggle between answers so stale data is never mistaken for fresh
    arr_rsp_out <= {1'b0, ~arr_rsp_out[17:0]};
    if (sys_rst_in) begin
      cnt <= 4'h0;
      arr_rsp_out <= '0;
    end else if (arr_req_in.req && !arr_rsp_out.done) begin
      if (cnt < lat_in) begin
        cnt <= cnt + 4'h1;
      end else begin
        cnt <= 4'h0;
        base = int'(arr_req_in.addr);
        arr_rsp_out.done <= 1'b1;
        arr_rsp_out.err <= 1'b0;
        arr_rsp_out.uncorr <= 1'b0;
        arr_rsp_out.rdata <= rd_word(base);
        case (arr_req_in.op)
          // real cells only clear bits, so reprogramming gives the AND
          ARR_PROGRAM: mem[base] = rd_word(base) & arr_req_in.wdata;
          ARR_ERASE: for (int i = 0; i < SECTOR_BYTES; i += 2) mem[base + i] = 16'hffff;
          ARR_BLANK: for (int i = 0; i < SECTOR_BYTES; i += 2)
            if (rd_word(base + i) !== 16'hffff) arr_rsp_out.err <= 1'b1;
          default: ;
        endcase
        if (arr_req_in.op inside {ARR_READ, ARR_BLANK} && inj_err_in) arr_rsp_out.err <= 1'b1;
        if (arr_req_in.op inside {ARR_READ, ARR_BLANK} && inj_uncorr_in) arr_rsp_out.uncorr <= 1'b1;
      end
    end
  end
endmodule

// >>> tb/tb_dfs_sequencer.sv
// self-checking bench for the data-flash command sequencer
`timescale 1ns/10ps
module tb_dfs_sequencer import dfs_pkg::*;;
  localparam logic [22:0] BASE = 23'h10_0000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic allowed = 1'b1;
  logic stop_req = 1'b0;
  logic ecc_s = 1'b0;
  logic ecc_d = 1'b0;
  logic [3:0] lat = 4'h1;
  logic inj_e = 1'b0;
  logic inj_u = 1'b0;
  logic [15:0] rdata;
  logic stop_ack;
  logic cmd_irq;
  logic err_irq;
  dfs_arr_req_s areq;
  dfs_arr_rsp_s arsp;
  int failures = 0;
  int num_checks = 0;

  always #5 clk = ~clk;

  dfs_sequencer i_dfs_sequencer (.mclk_in(clk), .sys_rst_in(rst), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata),
    .cmd_allowed_in(allowed), .stop_req_in(stop_req), .stop_ack_out(stop_ack),
    .arr_req_out(areq), .arr_rsp_in(arsp), .ecc_single_in(ecc_s), .ecc_double_in(ecc_d),
    .cmd_irq_out(cmd_irq), .err_irq_out(err_irq));
  dfs_flash_model i_dfs_flash_model (.mclk_in(clk), .sys_rst_in(rst), .arr_req_in(areq),
    .lat_in(lat), .inj_err_in(inj_e), .inj_uncorr_in(inj_u), .arr_rsp_out(arsp));

  // ----------------------------------------
  // bus and check tasks
  // ----------------------------------------
  task automatic final_report();
    if (failures == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic check(string nm, logic [15:0] exp, logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  task automatic rchk(string nm, logic [3:0] a, logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 check(nm, e, rdata);
  endtask

  // polls the complete flag; a stuck sequencer ends the run
  task automatic wait_idle();
    for (int i = 0; i < 300; i++) begin
      @(posedge clk);
      addr <= REG_STATUS;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 if (rdata[ST_CMD_COMPLETE_FLAG] === 1'b1) return;
    end
    failures++;
    final_report();
  endtask

  // all four word slots are always loaded; idx alone decides the count
  task automatic launch(logic [7:0] c, logic [22:0] a, logic [2:0] idx);
    wr(REG_PARAM_INDEX, 16'h0000);
    wr(REG_PARAM_WORD, {c, 1'b0, a[22:16]});
    wr(REG_PARAM_INDEX, 16'h0001);
    wr(REG_PARAM_WORD, a[15:0]);
    for (int k = 2; k <= 5; k++) begin
      wr(REG_PARAM_INDEX, 16'(k));
      wr(REG_PARAM_WORD, 16'h1000 + 16'(k));
    end
    wr(REG_PARAM_INDEX, {13'h0, idx});
    wr(REG_STATUS, 16'h0080);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_program();
    @(posedge clk);
    lat <= 4'h8;
    stop_req <= 1'b1;
    wr(REG_CONFIG, 16'h0001);
    launch(CMD_PROGRAM, BASE + 23'h10, 3'h5);
    #1 check("cmd_irq_busy", 16'h0, 16'(cmd_irq));
    check("stop_busy", 16'h0, 16'(stop_ack));
    wait_idle();
    check("stop_done", 16'h1, 16'(stop_ack));
    check("cmd_irq_done", 16'h1, 16'(cmd_irq));
    for (int k = 0; k < 5; k++)
      check("word", k < 4 ? 16'h1002 + 16'(k) : 16'hffff,
        i_dfs_flash_model.rd_word(int'(BASE) + 16 + 2 * k));
    launch(CMD_PROGRAM, BASE + 23'h40, 3'h2);
    wait_idle();
    check("word_one", 16'h1002, i_dfs_flash_model.rd_word(int'(BASE) + 64));
    check("word_next", 16'hffff, i_dfs_flash_model.rd_word(int'(BASE) + 66));
    @(posedge clk);
    lat <= 4'h1;
    stop_req <= 1'b0;
  endtask

  task automatic t_errors();
    logic [7:0] c [8] = '{CMD_PROGRAM, CMD_PROGRAM, CMD_PROGRAM, CMD_PROGRAM, CMD_PROGRAM,
      CMD_ERASE_SECTOR, CMD_ERASE_SECTOR, 8'h13};
    logic [22:0] a [8] = '{BASE + 23'h80, BASE + 23'h80, BASE + 23'h81, 23'h80,
      BASE + 23'h1ffc, BASE + 23'h80, BASE + 23'h80, BASE + 23'h80};
    logic [2:0] ix [8] = '{3'h1, 3'h6, 3'h5, 3'h5, 3'h5, 3'h2, 3'h1, 3'h1};
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      allowed <= (i != 6);
      launch(c[i], a[i], ix[i]);
      rchk("status_err", REG_STATUS, 16'h00a0);
      wr(REG_STATUS, 16'h0020);
    end
    @(posedge clk);
    allowed <= 1'b1;
    launch(CMD_PROGRAM, BASE + 23'h1ff8, 3'h5);
    wait_idle();
    rchk("status_edge", REG_STATUS, 16'h0080);
  endtask

  task automatic t_erase();
    wr(REG_PROTECT, 16'h8080);
    launch(CMD_ERASE_SECTOR, BASE + 23'h100, 3'h1);
    rchk("status_prot", REG_STATUS, 16'h0090);
    wr(REG_STATUS, 16'h0010);
    launch(CMD_ERASE_SECTOR, BASE + 23'h1e, 3'h1);
    wait_idle();
    rchk("status_erase", REG_STATUS, 16'h0080);
    check("erased", 16'hffff, i_dfs_flash_model.rd_word(int'(BASE) + 16));
    wr(REG_PROTECT, 16'h0000);
    @(posedge clk);
    inj_e <= 1'b1;
    inj_u <= 1'b1;
    launch(CMD_ERASE_SECTOR, BASE + 23'h200, 3'h1);
    wait_idle();
    rchk("status_blank", REG_STATUS, 16'h0083);
    @(posedge clk);
    inj_u <= 1'b0;
    launch(CMD_PROGRAM, BASE + 23'h200, 3'h2);
    wait_idle();
    rchk("status_verify", REG_STATUS, 16'h0082);
    @(posedge clk);
    inj_e <= 1'b0;
  endtask

  task automatic t_ecc();
    wr(REG_ERR_CONFIG, 16'h0003);
    @(posedge clk);
    ecc_s <= 1'b1;
    @(posedge clk);
    ecc_s <= 1'b0;
    #1 check("err_irq_single", 16'h1, 16'(err_irq));
    rchk("err_status", REG_ERR_STATUS, 16'h0001);
    wr(REG_ERR_STATUS, 16'h0001);
    wr(REG_ERR_CONFIG, 16'h0002);
    @(posedge clk);
    ecc_s <= 1'b1;
    @(posedge clk);
    ecc_s <= 1'b0;
    #1 check("err_irq_masked", 16'h0, 16'(err_irq));
    @(posedge clk);
    ecc_d <= 1'b1;
    @(posedge clk);
    ecc_d <= 1'b0;
    #1 check("err_irq_double", 16'h1, 16'(err_irq));
    wr(REG_ERR_STATUS, 16'h0003);
    #1 check("err_irq_clear", 16'h0, 16'(err_irq));
  endtask

  task automatic t_security();
    rchk("sec_reset", REG_SECURITY, 16'h005a);
    i_dfs_flash_model.mem[int'(SEC_BYTE_ADDR)] = 16'hff3c;
    wr(REG_SECURITY, 16'h0000);
    rchk("sec_held", REG_SECURITY, 16'h005a);
    @(posedge clk);
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    wait_idle();
    rchk("sec_reload", REG_SECURITY, 16'h003c);
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    wait_idle();
    rchk("status_reset", REG_STATUS, 16'h0080);
    rchk("unmapped", 4'h8, 16'h0000);
    t_program();
    t_errors();
    t_erase();
    t_ecc();
    t_security();
    final_report();
  end

  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    final_report();
  end
endmodule
